// ### wdc_pkg.sv
// constants and types shared by the watchdog control block
package wdc_pkg;
   // ==========================================================
   // register map, byte addresses on the avalon slave
   localparam logic [4:0] WDC_ADDR_CTRL   = 5'h00;
   localparam logic [4:0] WDC_ADDR_STATUS = 5'h04;
   localparam logic [4:0] WDC_ADDR_MASK   = 5'h08;
   localparam logic [4:0] WDC_ADDR_CMD    = 5'h0C;

   // ==========================================================
   // control/status field positions
   localparam int WDC_BIT_FLAG   = 7;
   localparam int WDC_BIT_IE     = 6;
   localparam int WDC_BIT_PER3   = 5;
   localparam int WDC_BIT_UNLOCK = 4;
   localparam int WDC_BIT_SRE    = 3;
   localparam int WDC_PER_LO_MSB = 2;

   // interrupt status / mask bits
   localparam int WDC_EV_TIMEOUT = 0;
   localparam int WDC_EV_RESET   = 1;
   localparam int WDC_EV_W       = 2;

   // command register bits
   localparam int WDC_CMD_RESTART = 0;
   localparam int WDC_CMD_VECTOR  = 1;

   // ==========================================================
   // reset values
   localparam logic [3:0]        WDC_PER_RST = 4'h0;
   localparam logic              WDC_SRE_RST = 1'b0;
   localparam logic [WDC_EV_W-1:0] WDC_EV_RST = 2'h0;

   // ==========================================================
   // timing
   localparam int          WDC_CLK_HZ        = 25000000;
   localparam int          WDC_OSC_HZ        = 128000;
   localparam int          WDC_UNLOCK_CYCLES = 4;
   localparam logic [2:0]  WDC_UNLOCK_LOAD   = 3'(WDC_UNLOCK_CYCLES);
   localparam int          WDC_BASE_SHIFT    = 11;
   localparam logic [3:0]  WDC_MAX_CODE      = 4'h9;
   localparam int          WDC_CNT_W         = 20;

   // ==========================================================
   // bus answer state
   typedef enum logic {
      WDC_BUS_IDLE = 1'b0,
      WDC_BUS_ACK  = 1'b1
   } wdc_bus_state_t;
endpackage

// ### wdc_counter.sv
// watchdog oscillator tick synchroniser and time-out counter
`timescale 1ns/1ps
module wdc_counter
   import wdc_pkg::*;
#(
   parameter int CNT_W      = WDC_CNT_W,
   parameter int BASE_SHIFT = WDC_BASE_SHIFT
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // oscillator and control
   input  wire logic       osc_in,
   input  wire logic       run,
   input  wire logic       restart,
   input  wire logic [3:0] period_code,
   // event
   output logic            timeout
);
   // ==========================================================
   // parameter check
   generate
      if (CNT_W != BASE_SHIFT + int'(WDC_MAX_CODE)) begin : g_bad
         $error("counter width does not fit the longest period");
      end
   endgenerate

   // ==========================================================
   // tick crossing
   logic             sync_a;
   logic             sync_b;
   logic             sync_c;
   logic             tick;
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] limit_m1;
   logic [3:0]       code;

   // oscillator runs unrelated to clk, only rising edges count
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         sync_c <= 1'b0;
      end else begin
         sync_a <= osc_in;
         sync_b <= sync_a;
         sync_c <= sync_b;
      end
   end
   assign tick = sync_b & ~sync_c;

   // ==========================================================
   // period decode, reserved codes run as the longest
   assign code     = (period_code > WDC_MAX_CODE) ? WDC_MAX_CODE : period_code;
   assign limit_m1 = {CNT_W{1'b1}} >> (WDC_MAX_CODE - code);

   // ==========================================================
   // counter; compare is >= so a shorter period fires on the next tick
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count   <= '0;
         timeout <= 1'b0;
      end else begin
         timeout <= 1'b0;
         if (restart || !run) begin
            count <= '0;
         end else if (tick) begin
            if (count >= limit_m1) begin
               count   <= '0;
               timeout <= 1'b1;
            end else begin
               count <= count + 1'b1;
            end
         end
      end
   end
endmodule // wdc_counter

// ### wdc_watchdog.sv
// watchdog timer control: register, protected change window, modes, bus slave
//
// Chosen here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
module wdc_watchdog
   import wdc_pkg::*;
#(
   parameter int CNT_W = WDC_CNT_W
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // avalon-mm slave
   input  wire logic [4:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   // system status
   input  wire logic        osc_in,
   input  wire logic        always_on_fuse,
   input  wire logic        watchdog_caused_reset_flag,
   input  wire logic        global_irq_enable,
   // requests out
   output logic             timeout_irq_request,
   output logic             system_reset_request,
   output logic             irq
);
   // ==========================================================
   // declarations
   wdc_bus_state_t      bus_state;
   wdc_bus_state_t      next_bus_state;
   logic                access;
   logic                commit;
   logic                wr_ctrl;
   logic                wr_status;
   logic                wr_mask;
   logic                wr_cmd;
   logic                timeout_irq_flag;
   logic                timeout_irq_enable;
   logic                system_reset_enable;
   logic [3:0]          timeout_period_select;
   logic                change_unlock_bit;
   logic [2:0]          unlock_count;
   logic                sre_eff;
   logic                ie_eff;
   logic                run;
   logic                timeout;
   logic                restart;
   logic                vector_ack;
   logic                ev_timeout;
   logic                ev_reset;
   logic [WDC_EV_W-1:0] ev_status;
   logic [WDC_EV_W-1:0] ev_mask;
   logic [WDC_EV_W-1:0] ev_set;
   logic [7:0]          ctrl_view;
   logic [7:0]          wd;
   logic [3:0]          wd_period;
   logic [31:0]         next_readdata;

   // ==========================================================
   // avalon slave: one wait state on every access
   assign access      = read | write;
   assign waitrequest = access & (bus_state == WDC_BUS_IDLE);
   assign commit      = access & (bus_state == WDC_BUS_ACK);

   always_comb begin
      next_bus_state = WDC_BUS_IDLE;
      unique case (bus_state)
         WDC_BUS_IDLE: next_bus_state = access ? WDC_BUS_ACK : WDC_BUS_IDLE;
         WDC_BUS_ACK:  next_bus_state = WDC_BUS_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bus_state <= WDC_BUS_IDLE;
      end else begin
         bus_state <= next_bus_state;
      end
   end

   // write strobes only in the cycle waitrequest is low
   assign wr_ctrl   = commit & write & byteenable[0] & (address == WDC_ADDR_CTRL);
   assign wr_status = commit & write & byteenable[0] & (address == WDC_ADDR_STATUS);
   assign wr_mask   = commit & write & byteenable[0] & (address == WDC_ADDR_MASK);
   assign wr_cmd    = commit & write & byteenable[0] & (address == WDC_ADDR_CMD);
   assign wd        = writedata[7:0];
   assign wd_period = {wd[WDC_BIT_PER3], wd[WDC_PER_LO_MSB:0]};

   assign restart    = wr_cmd & wd[WDC_CMD_RESTART];
   assign vector_ack = wr_cmd & wd[WDC_CMD_VECTOR];

   // ==========================================================
   // effective mode bits
   assign sre_eff = system_reset_enable | watchdog_caused_reset_flag
                  | always_on_fuse;
   assign ie_eff  = timeout_irq_enable & ~always_on_fuse;
   assign run     = sre_eff | ie_eff;

   // ==========================================================
   // control/status view, field layout
   always_comb begin
      ctrl_view                               = 8'h00;
      ctrl_view[WDC_BIT_FLAG]                 = timeout_irq_flag;
      ctrl_view[WDC_BIT_IE]                   = ie_eff;
      ctrl_view[WDC_BIT_PER3]                 = timeout_period_select[3];
      ctrl_view[WDC_BIT_UNLOCK]               = change_unlock_bit;
      ctrl_view[WDC_BIT_SRE]                  = sre_eff;
      ctrl_view[WDC_PER_LO_MSB:0]             = timeout_period_select[2:0];
   end

   // ==========================================================
   // read data, taken while waitrequest is high
   always_comb begin
      next_readdata = 32'h0000_0000;
      unique case (address)
         WDC_ADDR_CTRL:   next_readdata[7:0] = ctrl_view;
         WDC_ADDR_STATUS: next_readdata[WDC_EV_W-1:0] = ev_status;
         WDC_ADDR_MASK:   next_readdata[WDC_EV_W-1:0] = ev_mask;
         default:         next_readdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         readdata <= 32'h0000_0000;
      end else if (read && bus_state == WDC_BUS_IDLE) begin
         readdata <= next_readdata;
      end
   end

   // ==========================================================
   // change window: opened by unlock and reset-enable written together
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         change_unlock_bit <= 1'b0;
         unlock_count      <= 3'h0;
      end else if (wr_ctrl && wd[WDC_BIT_UNLOCK] && wd[WDC_BIT_SRE]) begin
         change_unlock_bit <= 1'b1;
         unlock_count      <= WDC_UNLOCK_LOAD;
      end else if (wr_ctrl && change_unlock_bit) begin
         change_unlock_bit <= 1'b0;
         unlock_count      <= 3'h0;
      end else if (unlock_count > 3'h1) begin
         unlock_count <= unlock_count - 3'h1;
      end else begin
         change_unlock_bit <= 1'b0;
         unlock_count      <= 3'h0;
      end
   end

   // ==========================================================
   // reset enable and period; clearing or re-timing is protected
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         system_reset_enable   <= WDC_SRE_RST;
         timeout_period_select <= WDC_PER_RST;
      end else if (wr_ctrl) begin
         if (change_unlock_bit && !wd[WDC_BIT_UNLOCK]) begin
            // reset flag still pins the bit on
            system_reset_enable   <= wd[WDC_BIT_SRE] | watchdog_caused_reset_flag;
            timeout_period_select <= wd_period;
         end else if (wd[WDC_BIT_SRE]) begin
            system_reset_enable <= 1'b1;
         end
      end
   end

   // ==========================================================
   // counter
   wdc_counter #(
      .CNT_W      (CNT_W),
      .BASE_SHIFT (WDC_BASE_SHIFT)
   ) u_counter (
      .clk         (clk),
      .resetn      (resetn),
      .osc_in      (osc_in),
      .run         (run),
      .restart     (restart),
      .period_code (timeout_period_select),
      .timeout     (timeout)
   );

   // ==========================================================
   // time-out action
   // combined mode: an unserviced flag at the next time-out means reset
   assign ev_timeout = timeout & ie_eff & ~(sre_eff & timeout_irq_flag);
   assign ev_reset   = timeout & sre_eff & (~ie_eff | timeout_irq_flag);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         system_reset_request <= 1'b0;
      end else begin
         system_reset_request <= ev_reset;
      end
   end

   // flag: set wins over vector or write-one clear
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         timeout_irq_flag <= 1'b0;
      end else if (ev_timeout) begin
         timeout_irq_flag <= 1'b1;
      end else if (vector_ack || (wr_ctrl && wd[WDC_BIT_FLAG])) begin
         timeout_irq_flag <= 1'b0;
      end
   end

   // enable: the vector drops it in combined mode, leaving reset mode
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         timeout_irq_enable <= 1'b0;
      end else if (wr_ctrl) begin
         timeout_irq_enable <= wd[WDC_BIT_IE];
      end else if (vector_ack && sre_eff) begin
         timeout_irq_enable <= 1'b0;
      end
   end

   assign timeout_irq_request = timeout_irq_flag & ie_eff & global_irq_enable;

   // ==========================================================
   // event status, write one to clear, set wins
   assign ev_set = {ev_reset, ev_timeout};

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ev_status <= WDC_EV_RST;
      end else begin
         ev_status <= ev_set | (ev_status & ~(wr_status ? wd[WDC_EV_W-1:0] : 2'h0));
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ev_mask <= WDC_EV_RST;
      end else if (wr_mask) begin
         ev_mask <= wd[WDC_EV_W-1:0];
      end
   end

   assign irq = |(ev_status & ev_mask);
endmodule // wdc_watchdog

// ### wdc_watchdog_props.sv
// concurrent checks on the watchdog control block ports
`timescale 1ns/1ps
module wdc_watchdog_props
   import wdc_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        resetn,
   // avalon-mm slave
   input wire logic [4:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] writedata,
   input wire logic [3:0]  byteenable,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   // system status
   input wire logic        osc_in,
   input wire logic        always_on_fuse,
   input wire logic        watchdog_caused_reset_flag,
   input wire logic        global_irq_enable,
   // requests out
   input wire logic        timeout_irq_request,
   input wire logic        system_reset_request,
   input wire logic        irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // ==========================================================
   // bus answer
   property p_wait_first; $rose(read) || $rose(write) |-> waitrequest; endproperty
   a_wait_first: assert property (p_wait_first) else $error("no wait on first cycle");
   property p_wait_one; (read || write) && waitrequest |=> !waitrequest; endproperty
   a_wait_one: assert property (p_wait_one) else $error("wait longer than one cycle");
   property p_upper; read && !waitrequest |-> readdata[31:8] == 24'h000000; endproperty
   a_upper: assert property (p_upper) else $error("upper read bits set");
   // ==========================================================
   // requests and overrides
   property p_gie; !global_irq_enable |-> !timeout_irq_request; endproperty
   a_gie: assert property (p_gie) else $error("request without global enable");
   property p_fuse_req; always_on_fuse |-> !timeout_irq_request; endproperty
   a_fuse_req: assert property (p_fuse_req) else $error("request with fuse");
   property p_pulse; system_reset_request |=> !system_reset_request; endproperty
   a_pulse: assert property (p_pulse) else $error("reset request too long");
   property p_fuse_read;
      read && !waitrequest && address == WDC_ADDR_CTRL && always_on_fuse && $past(always_on_fuse)
      |-> readdata[WDC_BIT_SRE] && !readdata[WDC_BIT_IE];
   endproperty
   a_fuse_read: assert property (p_fuse_read) else $error("fuse not forcing mode");
   property p_flag_read;
      read && !waitrequest && address == WDC_ADDR_CTRL && watchdog_caused_reset_flag
      && $past(watchdog_caused_reset_flag) |-> readdata[WDC_BIT_SRE];
   endproperty
   a_flag_read: assert property (p_flag_read) else $error("reset flag not forcing");
endmodule // wdc_watchdog_props

bind wdc_watchdog wdc_watchdog_props wdc_watchdog_props_i (
   .clk(clk), .resetn(resetn), .address(address), .read(read), .write(write),
   .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
   .waitrequest(waitrequest), .osc_in(osc_in), .always_on_fuse(always_on_fuse),
   .watchdog_caused_reset_flag(watchdog_caused_reset_flag),
   .global_irq_enable(global_irq_enable), .timeout_irq_request(timeout_irq_request),
   .system_reset_request(system_reset_request), .irq(irq));

// ### tb_top.sv
// self-checking bench for the watchdog control block
`timescale 1ns/1ps
module tb_top
   import wdc_pkg::*;
;
   logic        clk = 0, resetn = 0, read = 0, write = 0, osc_in = 0;
   logic        always_on_fuse = 0, watchdog_caused_reset_flag = 0, global_irq_enable = 0;
   logic [4:0]  address = 0;
   logic [31:0] writedata = 0, readdata;
   logic [3:0]  byteenable = 0;
   logic        waitrequest, timeout_irq_request, system_reset_request, irq;
   logic [7:0]  m;
   logic [7:0]  exp_q[$];
   int          mismatches = 0, total_checks = 0, cycles = 0, n, i;
   integer      seed = 31;

   wdc_watchdog wdc_watchdog_i (.clk(clk), .resetn(resetn), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .osc_in(osc_in), .always_on_fuse(always_on_fuse),
      .watchdog_caused_reset_flag(watchdog_caused_reset_flag),
      .global_irq_enable(global_irq_enable), .timeout_irq_request(timeout_irq_request),
      .system_reset_request(system_reset_request), .irq(irq));

   // ==========================================================
   // clock, oscillator, hang limit
   always #20 clk = ~clk;
   // oscillator far faster than real, so a period fits the run
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles % 2 == 1) osc_in <= !osc_in;
      if (cycles == 95000) begin
         mismatches++;
         give_verdict();
      end
   end

   // ==========================================================
   // tasks
   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                      input logic [3:0] be);
      @(posedge clk);
      read <= !w;
      write <= w;
      address <= a;
      writedata <= {24'h000000, d};
      byteenable <= be;
      do @(posedge clk); while (waitrequest !== 1'b0);
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 8'h00, 4'hF);
   endtask
   task automatic wait_ev(input logic rst);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while ((rst ? system_reset_request : timeout_irq_request) !== 1'b1);
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // ==========================================================
   // read data monitor, oldest note first
   always @(posedge clk) begin
      if (resetn && read && waitrequest === 1'b0) check("readdata", exp_q.pop_front(), readdata);
   end

   // ==========================================================
   // scenarios
   initial begin
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      rd(WDC_ADDR_CTRL, 8'h00);
      rd(5'h10, 8'h00);
      m = 8'($random(seed)) & 8'h03;
      wr(WDC_ADDR_MASK, m);
      rd(WDC_ADDR_MASK, m);
      global_irq_enable <= 1'b1;
      wr(WDC_ADDR_CTRL, 8'h40);
      rd(WDC_ADDR_CTRL, 8'h40);
      for (i = 0; i < 3; i++) begin
         repeat (5000 + ($random(seed) & 511)) @(posedge clk);
         @(negedge clk);
         check("early", 1'b0, timeout_irq_request);
         wr(WDC_ADDR_CMD, 8'h01);
      end
      wait_ev(1'b0);
      check("period0", 1'b1, n >= 8180 && n <= 8210);
      rd(WDC_ADDR_CTRL, 8'hC0);
      rd(WDC_ADDR_STATUS, 8'h01);
      @(negedge clk);
      check("irq", m[0], irq);
      wr(WDC_ADDR_MASK, 8'h03);
      @(negedge clk);
      check("irq", 1'b1, irq);
      wr(WDC_ADDR_MASK, 8'h00);
      @(negedge clk);
      check("irq", 1'b0, irq);
      wr(WDC_ADDR_MASK, 8'h03);
      wr(WDC_ADDR_STATUS, 8'h01);
      @(negedge clk);
      check("irq", 1'b0, irq);
      @(posedge clk);
      global_irq_enable <= 1'b0;
      @(negedge clk);
      check("request", 1'b0, timeout_irq_request);
      @(posedge clk);
      global_irq_enable <= 1'b1;
      @(negedge clk);
      check("request", 1'b1, timeout_irq_request);
      wr(WDC_ADDR_CTRL, 8'h00);
      rd(WDC_ADDR_CTRL, 8'h80);
      wr(WDC_ADDR_CTRL, 8'h80);
      rd(WDC_ADDR_CTRL, 8'h00);
      // protected change window
      wr(WDC_ADDR_CTRL, 8'h08);
      wr(WDC_ADDR_CTRL, 8'h01);
      rd(WDC_ADDR_CTRL, 8'h08);
      bus(1'b1, WDC_ADDR_MASK, 8'h00, 4'h0);
      rd(WDC_ADDR_MASK, 8'h03);
      wr(WDC_ADDR_CTRL, 8'h18);
      rd(WDC_ADDR_CTRL, 8'h18);
      rd(WDC_ADDR_CTRL, 8'h08);
      wr(WDC_ADDR_CTRL, 8'h01);
      rd(WDC_ADDR_CTRL, 8'h08);
      wr(WDC_ADDR_CTRL, 8'h18);
      wr(WDC_ADDR_CTRL, 8'h41);
      rd(WDC_ADDR_CTRL, 8'h41);
      wr(WDC_ADDR_CMD, 8'h01);
      wait_ev(1'b0);
      check("period1", 1'b1, n >= 16372 && n <= 16402);
      wr(WDC_ADDR_CTRL, 8'h80);
      rd(WDC_ADDR_CTRL, 8'h01);
      wr(WDC_ADDR_STATUS, 8'h03);
      // combined mode, handler never runs
      wr(WDC_ADDR_CTRL, 8'h18);
      wr(WDC_ADDR_CTRL, 8'h48);
      wr(WDC_ADDR_CMD, 8'h01);
      wait_ev(1'b0);
      rd(WDC_ADDR_CTRL, 8'hC8);
      wait_ev(1'b1);
      check("second", 1'b1, n >= 8160 && n <= 8210);
      rd(WDC_ADDR_STATUS, 8'h03);
      wr(WDC_ADDR_CMD, 8'h02);
      rd(WDC_ADDR_CTRL, 8'h08);
      wr(WDC_ADDR_CTRL, 8'h48);
      rd(WDC_ADDR_CTRL, 8'h48);
      // fuse and reset flag overrides
      always_on_fuse <= 1'b1;
      wr(WDC_ADDR_CTRL, 8'h40);
      rd(WDC_ADDR_CTRL, 8'h08);
      always_on_fuse <= 1'b0;
      watchdog_caused_reset_flag <= 1'b1;
      wr(WDC_ADDR_CTRL, 8'h18);
      wr(WDC_ADDR_CTRL, 8'h00);
      rd(WDC_ADDR_CTRL, 8'h08);
      watchdog_caused_reset_flag <= 1'b0;
      wr(WDC_ADDR_CTRL, 8'h18);
      wr(WDC_ADDR_CTRL, 8'h00);
      rd(WDC_ADDR_CTRL, 8'h00);
      give_verdict();
   end
endmodule // tb_top
